/* laser_seq_regs.vh */
// constants for the laser status and fault sequencer
`ifndef LASER_SEQ_REGS_VH
`define LASER_SEQ_REGS_VH

// register byte offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_FAULT 4'h8

// control register fields
`define CTRL_OEM_BIT 0
`define CTRL_PULSED_BIT 1
`define CTRL_RESET 2'h0

// status register fields
`define ST_READY_BIT 0
`define ST_SHUTTER_BIT 1
`define ST_INTLK_BIT 2
`define ST_TEMP_BIT 3
`define ST_LASE_BIT 4
`define ST_RF_BIT 5
`define ST_TICKLE_BIT 6
`define ST_PERMIT_BIT 7

// fault register fields
`define FL_CODE_LSB 0
`define FL_TEMP_BIT 3
`define FL_NOSTRIKE_BIT 4
`define FL_FREQ_BIT 5
`define FL_DUTY_BIT 6

// blink codes
`define CODE_NONE 3'h0
`define CODE_UNDER_V 3'h1
`define CODE_OVER_V 3'h2
`define CODE_RF_SW 3'h3
`define CODE_PWM_DRV 3'h4

// timing
`define CLK_HZ 125000000
`define CLK_MHZ 125
`define TICK_S 1
`define START_DELAY_S 4'h5
`define PAUSE_S 4'h4
`define FREQ_LIMIT_KHZ 100
`define FREQ_LIMIT_CYC (`CLK_MHZ * 1000 / `FREQ_LIMIT_KHZ)
`define PW_LIMIT_US 500
`define PW_LIMIT_CYC (`PW_LIMIT_US * `CLK_MHZ)
`define MIN_LASE_CYC 20'h00002
`define NOSTRIKE_DUTY_DIV 5'h14
`define MEAS_MAX 20'hFFFFF

`endif

/* sync2.v */
// two-flop synchroniser for a group of asynchronous levels
module sync2 #(
    parameter W = 1
) (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sync2

/* laser_status_fault_sequencer.v */
// laser status lamps, enable sequencing, fault blink codes and avalon registers
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`include "laser_seq_regs.vh"

module laser_status_fault_sequencer #(
    parameter [26:0] SEC_CYCLES = `CLK_HZ * `TICK_S,
    parameter [19:0] PW_LIMIT_CYCLES = `PW_LIMIT_CYC
) (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // avalon-mm slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // user inputs
    input wire interlock_in,
    input wire keyswitch_on,
    input wire reset_start_req,
    input wire shutter_req,
    input wire shutter_switch_open,
    input wire pwm_cmd,
    // sensed conditions
    input wire temp_ok_in,
    input wire under_voltage,
    input wire over_voltage,
    input wire rf_switch_fault,
    input wire pwm_drive_fault,
    input wire strike_ok,
    // lamps
    output reg interlock_lamp,
    output reg temperature_ok_lamp,
    output reg ready_lamp,
    output reg shutter_lamp,
    output reg lase_lamp,
    // user outputs, high means closed
    output reg out_interlock_open,
    output reg out_fault_detected,
    output reg out_laser_ready,
    output reg out_shutter_open,
    output reg out_lase_active,
    // drive
    output reg rf_power_en,
    output reg tickle_en,
    output reg rf_pwm_out
);
    localparam [3:0] BL_IDLE = 4'h1;
    localparam [3:0] BL_ON = 4'h2;
    localparam [3:0] BL_OFF = 4'h4;
    localparam [3:0] BL_PAUSE = 4'h8;
    localparam [19:0] FREQ_LIM_CYCLES = `FREQ_LIMIT_CYC;

    function [19:0] sat_inc;
        input [19:0] v;
        begin
            sat_inc = (v == `MEAS_MAX) ? v : v + 20'h00001;
        end
    endfunction

    wire [11:0] raw_in = {interlock_in, keyswitch_on, reset_start_req, shutter_req,
        shutter_switch_open, pwm_cmd, temp_ok_in, under_voltage, over_voltage,
        rf_switch_fault, pwm_drive_fault, strike_ok};
    wire [11:0] s_in;

    sync2 #(.W(12)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .d(raw_in),
        .q(s_in)
    );

    wire int_ok = s_in[11];
    wire key_s = s_in[10];
    wire rst_req_s = s_in[9];
    wire sh_req_s = s_in[8];
    wire sh_sw_s = s_in[7];
    wire pwm_s = s_in[6];
    wire temp_s = s_in[5];
    wire strike_s = s_in[0];

    reg [1:0] ctrl_r;
    wire oem = ctrl_r[`CTRL_OEM_BIT];
    wire pulsed = ctrl_r[`CTRL_PULSED_BIT];

    reg key_d_r, rst_req_d_r, pwm_d_r, ready_d_r, shut_d_r;
    reg ready_r, temp_fault_r;
    reg [2:0] code_r;
    reg [3:0] hold_cnt_r;
    reg [26:0] hold_pre_r;
    reg [19:0] high_cnt_r, period_cnt_r, last_period_r, last_high_r;
    reg freq_lim_r, duty_lim_r;
    reg [3:0] bl_state_r;
    reg [26:0] bl_pre_r;
    reg [2:0] bl_cnt_r;
    reg [3:0] pause_cnt_r;
    reg flash_r;
    reg [26:0] fl_pre_r;

    // synchroniser outputs hold reset values for two edges; ignore them until then
    reg [1:0] settle_r;
    wire settled = settle_r[1];

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_r <= 2'h0;
        end else if (!settled) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    // temperature fault latches until power cycle
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_fault_r <= 1'b0;
        end else if (settled && !temp_s) begin
            temp_fault_r <= 1'b1;
        end
    end

    // first coded fault latched; later faults do not replace it
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_r <= `CODE_NONE;
        end else if (code_r == `CODE_NONE) begin
            if (s_in[4]) begin
                code_r <= `CODE_UNDER_V;
            end else if (s_in[3]) begin
                code_r <= `CODE_OVER_V;
            end else if (s_in[2]) begin
                code_r <= `CODE_RF_SW;
            end else if (s_in[1]) begin
                code_r <= `CODE_PWM_DRV;
            end
        end
    end

    wire good = int_ok && !temp_fault_r && (code_r == `CODE_NONE);
    wire arm = (key_s && !key_d_r) || (key_s && rst_req_s && !rst_req_d_r);
    wire shutter_on = sh_req_s && (oem || sh_sw_s);
    wire enabled = ready_r && shutter_on && good;

    // ready function
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_r <= 1'b0;
            key_d_r <= 1'b1;
            rst_req_d_r <= 1'b1;
        end else begin
            // key held on through power-up is no off-to-on cycle
            key_d_r <= settled ? key_s : 1'b1;
            rst_req_d_r <= settled ? rst_req_s : 1'b1;
            if (oem) begin
                ready_r <= good;
            end else if (!good || !key_s) begin
                ready_r <= 1'b0;
            end else if (arm) begin
                ready_r <= 1'b1;
            end
        end
    end

    // start-up hold in seconds, restarted on each qualifying entry
    wire hold_load = !oem && ((ready_r && !ready_d_r) || (enabled && !shut_d_r));
    wire hold_tick = (hold_pre_r == SEC_CYCLES - 27'h1);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_d_r <= 1'b0;
            shut_d_r <= 1'b0;
            hold_cnt_r <= 4'h0;
            hold_pre_r <= 27'h0;
        end else begin
            ready_d_r <= ready_r;
            shut_d_r <= enabled;
            if (!ready_r || oem) begin
                hold_cnt_r <= 4'h0;
                hold_pre_r <= 27'h0;
            end else if (hold_load) begin
                hold_cnt_r <= `START_DELAY_S;
                hold_pre_r <= 27'h0;
            end else if (hold_cnt_r != 4'h0) begin
                hold_pre_r <= hold_tick ? 27'h0 : hold_pre_r + 27'h1;
                if (hold_tick) begin
                    hold_cnt_r <= hold_cnt_r - 4'h1;
                end
            end
        end
    end

    wire permit = enabled && (hold_cnt_r == 4'h0);

    // command pulse measurement
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_d_r <= 1'b0;
            high_cnt_r <= 20'h0;
            period_cnt_r <= 20'h0;
            last_period_r <= `MEAS_MAX;
            last_high_r <= 20'h0;
            freq_lim_r <= 1'b0;
            duty_lim_r <= 1'b0;
        end else begin
            pwm_d_r <= pwm_s;
            if (pwm_s && !pwm_d_r) begin
                last_period_r <= period_cnt_r;
                last_high_r <= high_cnt_r;
                period_cnt_r <= 20'h1;
                high_cnt_r <= 20'h1;
                freq_lim_r <= pulsed && (period_cnt_r <= FREQ_LIM_CYCLES);
                duty_lim_r <= pulsed && (({high_cnt_r, 1'b0} >= {1'b0, period_cnt_r}) ||
                    (high_cnt_r >= PW_LIMIT_CYCLES));
            end else begin
                period_cnt_r <= sat_inc(period_cnt_r);
                high_cnt_r <= pwm_s ? sat_inc(high_cnt_r) : high_cnt_r;
                if (period_cnt_r > FREQ_LIM_CYCLES) begin
                    freq_lim_r <= 1'b0;
                end
                if (pwm_s && pulsed && high_cnt_r >= PW_LIMIT_CYCLES) begin
                    duty_lim_r <= 1'b1;
                end
            end
        end
    end

    wire [24:0] high_x20 = high_cnt_r * `NOSTRIKE_DUTY_DIV;
    wire duty_ok = !(!strike_s && high_x20 >= {5'h0, last_period_r});
    wire lasing = permit && pwm_s && high_cnt_r >= `MIN_LASE_CYC && duty_ok;

    // coded blink sequencer
    wire bl_tick = (bl_pre_r == SEC_CYCLES - 27'h1);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bl_state_r <= BL_IDLE;
            bl_pre_r <= 27'h0;
            bl_cnt_r <= 3'h0;
            pause_cnt_r <= 4'h0;
        end else begin
            bl_pre_r <= (bl_tick || bl_state_r == BL_IDLE) ? 27'h0 : bl_pre_r + 27'h1;
            case (bl_state_r)
                BL_IDLE: begin
                    if (code_r != `CODE_NONE) begin
                        bl_state_r <= BL_ON;
                        bl_cnt_r <= 3'h1;
                    end
                end
                BL_ON: begin
                    if (bl_tick) begin
                        bl_state_r <= BL_OFF;
                    end
                end
                BL_OFF: begin
                    if (bl_tick) begin
                        if (bl_cnt_r == code_r) begin
                            bl_state_r <= BL_PAUSE;
                            pause_cnt_r <= `PAUSE_S;
                        end else begin
                            bl_state_r <= BL_ON;
                            bl_cnt_r <= bl_cnt_r + 3'h1;
                        end
                    end
                end
                BL_PAUSE: begin
                    if (bl_tick) begin
                        pause_cnt_r <= pause_cnt_r - 4'h1;
                        if (pause_cnt_r == 4'h1) begin
                            bl_state_r <= BL_ON;
                            bl_cnt_r <= 3'h1;
                        end
                    end
                end
                default: begin
                    bl_state_r <= BL_IDLE;
                end
            endcase
        end
    end

    // no-strike flasher, restarted when the condition appears
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fl_pre_r <= 27'h0;
            flash_r <= 1'b0;
        end else if (strike_s) begin
            fl_pre_r <= 27'h0;
            flash_r <= 1'b1;
        end else if (fl_pre_r == SEC_CYCLES - 27'h1) begin
            fl_pre_r <= 27'h0;
            flash_r <= !flash_r;
        end else begin
            fl_pre_r <= fl_pre_r + 27'h1;
        end
    end

    // lamps, user outputs and drive, all registered
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            interlock_lamp <= 1'b0;
            temperature_ok_lamp <= 1'b0;
            ready_lamp <= 1'b0;
            shutter_lamp <= 1'b0;
            lase_lamp <= 1'b0;
            out_interlock_open <= 1'b0;
            out_fault_detected <= 1'b0;
            out_laser_ready <= 1'b0;
            out_shutter_open <= 1'b0;
            out_lase_active <= 1'b0;
            rf_power_en <= 1'b0;
            tickle_en <= 1'b0;
            rf_pwm_out <= 1'b0;
        end else begin
            interlock_lamp <= int_ok;
            temperature_ok_lamp <= !temp_fault_r;
            ready_lamp <= (code_r != `CODE_NONE) ? (bl_state_r == BL_ON) : ready_r;
            shutter_lamp <= strike_s ? shutter_on : (shutter_on && flash_r);
            lase_lamp <= lasing;
            out_interlock_open <= !int_ok;
            out_fault_detected <= temp_fault_r || !strike_s || freq_lim_r || duty_lim_r ||
                (!oem && sh_req_s && !sh_sw_s);
            out_laser_ready <= ready_r;
            out_shutter_open <= shutter_on;
            out_lase_active <= lasing;
            rf_power_en <= enabled;
            tickle_en <= enabled && !permit;
            rf_pwm_out <= lasing;
        end
    end

    // avalon slave: one wait cycle, then one cycle with waitrequest low
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            ctrl_r <= `CTRL_RESET;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                case (address)
                    `REG_CTRL: readdata <= {30'h0, ctrl_r};
                    `REG_STATUS: readdata <= {24'h0, permit, tickle_en, rf_power_en, lase_lamp,
                        !temp_fault_r, int_ok, shutter_on, ready_r};
                    `REG_FAULT: readdata <= {25'h0, duty_lim_r, freq_lim_r, !strike_s,
                        temp_fault_r, code_r};
                    default: readdata <= 32'h0;
                endcase
            end
            if (write && !waitrequest && address == `REG_CTRL && byteenable[0]) begin
                ctrl_r <= writedata[1:0];
            end
        end
    end
endmodule // laser_status_fault_sequencer

/* laser_seq_checker_assertions.sv */
// concurrent checks on the laser status and fault sequencer ports
module laser_seq_checker #(
    parameter [26:0] SEC_CYCLES = 27'h7735940
) (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // bus handshake
    input wire read,
    input wire write,
    input wire waitrequest,
    // pins in
    input wire interlock_in,
    input wire temp_ok_in,
    input wire pwm_cmd,
    // lamps and outputs
    input wire interlock_lamp,
    input wire temperature_ok_lamp,
    input wire ready_lamp,
    input wire lase_lamp,
    input wire out_interlock_open,
    input wire out_lase_active,
    input wire rf_power_en,
    input wire tickle_en,
    input wire rf_pwm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    reg [2:0] up_r;
    reg [31:0] tk_r;
    // cycles since reset and length of the current tickle run
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            up_r <= 3'h0;
            tk_r <= 32'h0;
        end else begin
            if (up_r != 3'h7)
                up_r <= up_r + 3'h1;
            tk_r <= tickle_en ? tk_r + 32'h1 : 32'h0;
        end
    end
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered");
    a_wait_once: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_rf_ready: assert property (rf_power_en |-> ready_lamp)
        else $error("rf power without ready");
    a_tickle_rf: assert property (tickle_en |-> rf_power_en)
        else $error("tickle without rf power");
    a_pwm_gate: assert property (rf_pwm_out |-> rf_power_en && !tickle_en)
        else $error("drive pulse while gated");
    a_pwm_cause: assert property (!pwm_cmd [*5] |-> !rf_pwm_out)
        else $error("drive pulse without command");
    a_lase_mirror: assert property (up_r == 3'h7 |-> out_lase_active == lase_lamp)
        else $error("lase output differs from lamp");
    a_intlk_good: assert property ((up_r == 3'h7 && interlock_in) [*6]
        |-> interlock_lamp && !out_interlock_open)
        else $error("interlock lamp not good");
    a_intlk_open: assert property (!interlock_in [*6]
        |-> !interlock_lamp && out_interlock_open && !rf_power_en)
        else $error("interlock open not shown");
    a_temp_bad: assert property (!temp_ok_in [*6] |-> !temperature_ok_lamp && !rf_power_en)
        else $error("temperature fault not shown");
    a_tickle_len: assert property (tk_r <= SEC_CYCLES * 32'h6 + 32'h8)
        else $error("tickle runs too long");
    c_rf_on: cover property ($rose(rf_power_en));
    c_pulse: cover property ($rose(rf_pwm_out));
    c_tickle_end: cover property ($fell(tickle_en));
endmodule // laser_seq_checker

bind laser_status_fault_sequencer laser_seq_checker #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .read(read), .write(write),
    .waitrequest(waitrequest), .interlock_in(interlock_in), .temp_ok_in(temp_ok_in),
    .pwm_cmd(pwm_cmd), .interlock_lamp(interlock_lamp),
    .temperature_ok_lamp(temperature_ok_lamp), .ready_lamp(ready_lamp),
    .lase_lamp(lase_lamp), .out_interlock_open(out_interlock_open),
    .out_lase_active(out_lase_active), .rf_power_en(rf_power_en),
    .tickle_en(tickle_en), .rf_pwm_out(rf_pwm_out));

/* host_ctrl_model.sv */
// host controller model driving command pulses on the user connector
module host_ctrl_model (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // lamps seen by the host
    input wire ready_lamp,
    input wire shutter_lamp,
    // pulse settings
    input wire run,
    input wire [19:0] hi_cyc,
    input wire [19:0] per_cyc,
    // command pin
    output reg pwm_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [19:0] ph_r;
    // pulses only once ready and shutter are shown
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_r <= 20'h0;
            pwm_cmd <= 1'b0;
        end else if (run && ready_lamp && shutter_lamp) begin
            ph_r <= (ph_r + 20'h1 >= per_cyc) ? 20'h0 : ph_r + 20'h1;
            pwm_cmd <= ph_r < hi_cyc;
        end else begin
            ph_r <= 20'h0;
            pwm_cmd <= 1'b0;
        end
    end
endmodule // host_ctrl_model

/* laser_status_fault_sequencer_bench.sv */
// self-checking bench for the laser status and fault sequencer
`include "laser_seq_regs.vh"
module laser_status_fault_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 20;
    reg ref_clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, run = 1'b0;
    reg [3:0] address = 4'h0, flt = 4'h0;
    reg [31:0] writedata = 32'h0;
    reg [19:0] hi_cyc = 20'h0, per_cyc = 20'h0;
    reg interlock_in = 1'b0, keyswitch_on = 1'b0, shutter_req = 1'b0;
    reg shutter_switch_open = 1'b0, temp_ok_in = 1'b1, strike_ok = 1'b1;
    wire [31:0] readdata;
    wire waitrequest, pwm_cmd, interlock_lamp, temperature_ok_lamp, ready_lamp;
    wire shutter_lamp, lase_lamp, out_interlock_open, out_fault_detected;
    wire out_laser_ready, out_shutter_open, out_lase_active, rf_power_en, tickle_en, rf_pwm_out;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    laser_status_fault_sequencer #(.SEC_CYCLES(SEC), .PW_LIMIT_CYCLES(40)) i_dut (
        .ref_clk, .arst_n, .address, .read, .write, .writedata, .byteenable(4'hF),
        .readdata, .waitrequest, .interlock_in, .keyswitch_on, .reset_start_req(1'b0),
        .shutter_req, .shutter_switch_open, .pwm_cmd, .temp_ok_in,
        .under_voltage(flt[0]), .over_voltage(flt[1]), .rf_switch_fault(flt[2]),
        .pwm_drive_fault(flt[3]), .strike_ok, .interlock_lamp, .temperature_ok_lamp,
        .ready_lamp, .shutter_lamp, .lase_lamp, .out_interlock_open, .out_fault_detected,
        .out_laser_ready, .out_shutter_open, .out_lase_active, .rf_power_en, .tickle_en,
        .rf_pwm_out);
    host_ctrl_model i_host (.ref_clk, .arst_n, .ready_lamp, .shutter_lamp, .run,
        .hi_cyc, .per_cyc, .pwm_cmd);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end
    task stop_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one avalon access, held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chk("bus answer", 1, n < 50);
    endtask
    task do_reset;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        tick(3);
        arst_n <= 1'b1;
        tick(2);
    endtask
    task s_regs;
        logic [31:0] q;
        bus(0, `REG_CTRL, 0, q);
        chk("ctrl reset", 0, q);
        bus(1, `REG_CTRL, 32'h3, q);
        bus(0, `REG_CTRL, 0, q);
        chk("ctrl", 3, q);
        bus(1, `REG_STATUS, 32'hFF, q);
        bus(0, 4'hC, 0, q);
        chk("unmapped", 0, q);
        bus(0, `REG_STATUS, 0, q);
        chk("status ro", 32'h00000008, q);
        bus(1, `REG_CTRL, 32'h1, q);
    endtask
    task s_oem;
        int n;
        interlock_in <= 1'b1;
        temp_ok_in <= 1'b1;
        tick(10);
        chk("oem ready", 1, ready_lamp);
        chk("rf idle", 0, rf_power_en);
        shutter_req <= 1'b1;
        shutter_switch_open <= 1'b1;
        tick(8);
        chk("rf on", 1, rf_power_en);
        chk("no tickle", 0, tickle_en);
        run <= 1'b1;
        hi_cyc <= 20'h0000A;
        per_cyc <= 20'h00064;
        n = 0;
        while (lase_lamp !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("lase", 1, lase_lamp);
        chk("ready out", 1, out_laser_ready);
        interlock_in <= 1'b0;
        tick(10);
        chk("intlk out", 1, out_interlock_open);
        interlock_in <= 1'b1;
        tick(8);
        chk("ready back", 1, ready_lamp);
    endtask
    task s_key;
        int n;
        run <= 1'b0;
        shutter_switch_open <= 1'b0;
        do_reset();
        tick(10);
        chk("no key", 0, ready_lamp);
        keyswitch_on <= 1'b1;
        tick(8);
        chk("key ready", 1, ready_lamp);
        chk("shut closed", 0, shutter_lamp);
        shutter_switch_open <= 1'b1;
        run <= 1'b1;
        tick(8);
        chk("shutter", 1, out_shutter_open);
        chk("tickle", 1, tickle_en);
        n = 0;
        while (rf_pwm_out !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("hold min", 1, n >= 4 * SEC - 10);
        chk("hold max", 1, n < 6 * SEC);
    endtask
    task s_fault;
        logic [31:0] q;
        int c, k, p;
        for (c = 1; c <= 4; c++) begin
            do_reset();
            flt <= 4'h1 << (c - 1);
            tick(5);
            flt <= 4'h0;
            tick(2 * SEC);
            bus(0, `REG_FAULT, 0, q);
            chk("code", c, q[2:0]);
            k = 0;
            p = ready_lamp;
            repeat ((2 * c + 4) * SEC) begin
                tick(1);
                k += (ready_lamp === 1'b1 && p == 0);
                p = ready_lamp;
            end
            chk("blinks", c, k);
        end
    endtask
    task s_limits;
        logic [31:0] q;
        int k, p;
        do_reset();
        tick(10);
        chk("key held", 0, out_laser_ready);
        bus(1, `REG_CTRL, 32'h3, q);
        per_cyc <= 20'h003E8;
        tick(3000);
        bus(0, `REG_FAULT, 0, q);
        chk("freq limit", 1, q[5]);
        per_cyc <= 20'h007D0;
        tick(5000);
        bus(0, `REG_FAULT, 0, q);
        chk("freq clear", 0, q[5]);
        hi_cyc <= 20'h00028;
        tick(5000);
        bus(0, `REG_FAULT, 0, q);
        chk("width limit", 1, q[6]);
        strike_ok <= 1'b0;
        k = 0;
        p = shutter_lamp;
        repeat (5 * SEC) begin
            tick(1);
            k += (shutter_lamp !== p);
            p = shutter_lamp;
        end
        chk("flash", 1, k >= 2);
        chk("fault out", 1, out_fault_detected);
        strike_ok <= 1'b1;
        tick(3 * SEC);
        chk("steady", 1, shutter_lamp);
    endtask
    initial begin
        tick(3);
        arst_n <= 1'b1;
        tick(2);
        s_regs();
        s_oem();
        s_key();
        s_fault();
        s_limits();
        stop_test();
    end
endmodule // laser_status_fault_sequencer_bench
